// ---- dpcac_pkg.sv ----
// Purpose: constants for the shared-RAM consistency access controller
// Assumes: host I/O port with byte offsets from module_base_address
// Notes: status bit layout beyond the acknowledge bit is chosen locally
package dpcac_pkg;
   localparam logic [7:0] DPCAC_OFF_PTR = 8'h00;
   localparam logic [7:0] DPCAC_OFF_DATA = 8'h02;
   localparam logic [7:0] DPCAC_OFF_DATA_INC = 8'h04;
   localparam logic [7:0] DPCAC_OFF_TOR = 8'h08;
   localparam logic [7:0] DPCAC_OFF_MODE = 8'h0a;
   localparam logic [7:0] DPCAC_OFF_REQ = 8'h18;
   localparam logic [7:0] DPCAC_OFF_STATUS = 8'h19;
   localparam logic [7:0] DPCAC_REQ_READ = 8'h01;
   localparam logic [7:0] DPCAC_REQ_WRITE = 8'h02;
   localparam logic [7:0] DPCAC_REQ_CLEAR = 8'h00;
   localparam int DPCAC_BIT_TIMEOUT = 0;
   localparam int DPCAC_BIT_RCONS = 1;
   localparam int DPCAC_BIT_WCONS = 2;
   localparam int DPCAC_BIT_PEER = 3;
   localparam int DPCAC_BIT_CONFLICT = 4;
   localparam int DPCAC_BIT_ACK = 5;
   localparam int DPCAC_BIT_LOCK = 6;
   localparam int DPCAC_AW = 14;
   localparam logic [DPCAC_AW-1:0] DPCAC_INC_WORD = 14'h0002;
   localparam logic [DPCAC_AW-1:0] DPCAC_INC_BYTE = 14'h0001;
   localparam logic [15:0] DPCAC_TOR_RESET = 16'hffff;
   // One timer tick per microsecond at 200 MHz
   localparam int DPCAC_TICK_NS = 1000;
   localparam int DPCAC_CLK_NS = 5;
   localparam int DPCAC_TICK_CYC = DPCAC_TICK_NS / DPCAC_CLK_NS;
   localparam logic [7:0] DPCAC_TICK_MAX = 8'(DPCAC_TICK_CYC - 1);
endpackage

// ---- dpcac_timer.sv ----
// Purpose: abort timer for peer requests during host consistent access
// Assumes: tick is a one-cycle enable, one per microsecond
// Notes: expired is a one-cycle pulse, counter reloads while not running
`timescale 1ns/1ps
module dpcac_timer (
   input wire logic ref_clk,
   input wire logic rst_n,
   input wire logic run,
   input wire logic tick,
   input wire logic [15:0] reload,
   output logic expired
);
   import dpcac_pkg::*;
   typedef struct packed {
      logic [15:0] cnt;
      logic expired;
      logic done;
   } dpcac_tmr_s;
   dpcac_tmr_s s_r, s_nxt;
   always_comb begin
      s_nxt = s_r;
      s_nxt.expired = 1'b0;
      if (!run) begin
         s_nxt.cnt = reload;
         s_nxt.done = 1'b0;
      end else if (tick && !s_r.done) begin
         if (s_r.cnt == 16'h0000) begin
            s_nxt.expired = 1'b1;
            s_nxt.done = 1'b1;
         end else begin
            s_nxt.cnt = s_r.cnt - 16'h0001;
         end
      end
   end
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         s_r <= '0;
      end else begin
         s_r <= s_nxt;
      end
   end
   assign expired = s_r.expired;
endmodule

// ---- dpcac_ctrl.sv ----
// Purpose: consistency arbitration guarding host access to the shared RAM
// Assumes: synchronous host I/O strobes on ref_clk; peer request is a pin
// Notes: shared RAM itself sits outside; this block drives its host port
`timescale 1ns/1ps
module dpcac_ctrl (
   input wire logic ref_clk,
   input wire logic rst_n,
   input wire logic io_wr,
   input wire logic io_rd,
   input wire logic [7:0] io_addr,
   input wire logic io_word,
   input wire logic [15:0] io_wdata,
   output logic [15:0] io_rdata,
   output logic io_ready,
   input wire logic peer_consistency_request,
   input wire logic peer_done,
   output logic peer_ready,
   output logic [dpcac_pkg::DPCAC_AW-1:0] ram_addr,
   output logic ram_wr,
   output logic ram_rd,
   output logic ram_word,
   output logic [15:0] ram_wdata,
   input wire logic [15:0] ram_rdata,
   output logic host_irq,
   output logic host_consistency_ack_n
);
   import dpcac_pkg::*;
   typedef enum logic [1:0] {
      DPCAC_IDLE = 2'b00,
      DPCAC_ACTIVE = 2'b01,
      DPCAC_LOCKED = 2'b10
   } dpcac_st_e;
   typedef struct packed {
      dpcac_st_e st;
      logic [2:0] peer_sync;
      logic peer_q;
      logic peer_busy;
      logic peer_fin;
      logic rcons;
      logic wcons;
      logic conflict;
      logic timeout;
      logic irq_mode;
      logic [15:0] timeout_reload_value;
      logic [DPCAC_AW-1:0] ptr;
      logic [7:0] tick_cnt;
      logic tick;
      logic [15:0] rdata;
      logic ready;
      logic [DPCAC_AW-1:0] ram_addr;
      logic ram_wr;
      logic ram_rd;
      logic ram_word;
      logic [15:0] ram_wdata;
      logic irq;
      logic ack_n;
      logic peer_ready;
   } dpcac_s;
   dpcac_s s_r, s_nxt;
   logic expired;
   logic [7:0] status;
   logic peer_req;
   logic host_ok;
   logic data_acc;
   logic inc_acc;

   dpcac_timer u_timer (
      .ref_clk(ref_clk),
      .rst_n(rst_n),
      .run(s_r.st == DPCAC_ACTIVE && s_r.peer_q && !s_r.ack_n && !s_r.irq_mode),
      .tick(s_r.tick),
      .reload(s_r.timeout_reload_value),
      .expired(expired)
   );

   // Pin sampled through three stages; a change counts when the last two agree
   assign peer_req = (s_r.peer_sync[2] == s_r.peer_sync[1]) ? s_r.peer_sync[1] : s_r.peer_q;
   assign host_ok = (s_r.st == DPCAC_ACTIVE) && !s_r.peer_busy;
   assign data_acc = (io_addr == DPCAC_OFF_DATA) || (io_addr == DPCAC_OFF_DATA_INC);
   assign inc_acc = io_addr == DPCAC_OFF_DATA_INC;

   always_comb begin
      status = 8'h00;
      status[DPCAC_BIT_TIMEOUT] = s_r.timeout;
      status[DPCAC_BIT_RCONS] = s_r.rcons;
      status[DPCAC_BIT_WCONS] = s_r.wcons;
      status[DPCAC_BIT_PEER] = s_r.peer_q;
      status[DPCAC_BIT_CONFLICT] = s_r.conflict;
      status[DPCAC_BIT_ACK] = s_r.ack_n;
      status[DPCAC_BIT_LOCK] = s_r.st == DPCAC_LOCKED;
   end

   always_comb begin
      s_nxt = s_r;
      s_nxt.peer_sync = {s_r.peer_sync[1:0], peer_consistency_request};
      s_nxt.peer_q = peer_req;
      s_nxt.ram_wr = 1'b0;
      s_nxt.ram_rd = 1'b0;
      s_nxt.ready = 1'b0;
      // Microsecond tick divider for the abort timer
      s_nxt.tick = 1'b0;
      if (s_r.tick_cnt == DPCAC_TICK_MAX) begin
         s_nxt.tick_cnt = 8'h00;
         s_nxt.tick = 1'b1;
      end else begin
         s_nxt.tick_cnt = s_r.tick_cnt + 8'h01;
      end
      // Peer owns the RAM from grant until it reports done; the done mark is
      // held until the synchronised request falls, since that lags the pulse
      if (peer_done) begin
         s_nxt.peer_busy = 1'b0;
         s_nxt.peer_fin = 1'b1;
      end else if (!peer_req) begin
         s_nxt.peer_fin = 1'b0;
      end else if (!s_r.peer_fin && s_r.st != DPCAC_ACTIVE) begin
         s_nxt.peer_busy = 1'b1;
      end
      if (io_wr) begin
         s_nxt.ready = 1'b1;
         case (io_addr)
            DPCAC_OFF_PTR: s_nxt.ptr = io_wdata[DPCAC_AW-1:0];
            DPCAC_OFF_TOR: s_nxt.timeout_reload_value = io_wdata;
            DPCAC_OFF_MODE: s_nxt.irq_mode = io_wdata[0];
            DPCAC_OFF_REQ: begin
               if (io_wdata[7:0] == DPCAC_REQ_CLEAR) begin
                  s_nxt.st = DPCAC_IDLE;
                  s_nxt.timeout = 1'b0;
                  s_nxt.conflict = 1'b0;
                  s_nxt.irq = 1'b0;
                  s_nxt.rcons = 1'b0;
                  s_nxt.wcons = 1'b0;
               end else if (s_r.st == DPCAC_IDLE) begin
                  if (io_wdata[7:0] == DPCAC_REQ_READ) begin
                     s_nxt.rcons = 1'b1;
                     s_nxt.st = DPCAC_ACTIVE;
                  end else if (io_wdata[7:0] == DPCAC_REQ_WRITE) begin
                     s_nxt.wcons = 1'b1;
                     s_nxt.st = DPCAC_ACTIVE;
                  end
               end
            end
            default: begin
               if (data_acc) begin
                  if (host_ok) begin
                     s_nxt.ram_wr = 1'b1;
                     s_nxt.ram_addr = s_r.ptr;
                     s_nxt.ram_word = io_word;
                     s_nxt.ram_wdata = io_wdata;
                     if (inc_acc) begin
                        s_nxt.ptr = s_r.ptr + (io_word ? DPCAC_INC_WORD : DPCAC_INC_BYTE);
                     end
                  end else if (s_r.st != DPCAC_LOCKED) begin
                     s_nxt.ready = 1'b0; // Braked until granted and any peer access finishes
                  end
               end
            end
         endcase
      end else if (io_rd) begin
         s_nxt.ready = 1'b1;
         s_nxt.rdata = 16'h0000;
         case (io_addr)
            DPCAC_OFF_PTR: s_nxt.rdata = 16'(s_r.ptr);
            DPCAC_OFF_TOR: s_nxt.rdata = s_r.timeout_reload_value;
            DPCAC_OFF_MODE: s_nxt.rdata = 16'(s_r.irq_mode);
            DPCAC_OFF_STATUS: s_nxt.rdata = 16'(status);
            DPCAC_OFF_REQ: begin
               s_nxt.rdata = 16'(status);
               s_nxt.rcons = 1'b0;
               s_nxt.wcons = 1'b0;
               s_nxt.irq = 1'b0;
               if (s_r.st == DPCAC_ACTIVE) begin
                  s_nxt.st = DPCAC_IDLE;
               end
            end
            default: begin
               if (data_acc && host_ok) begin
                  s_nxt.ram_rd = 1'b1;
                  s_nxt.ram_addr = s_r.ptr;
                  s_nxt.ram_word = io_word;
                  s_nxt.rdata = io_word ? ram_rdata : {8'h00, ram_rdata[7:0]};
                  if (inc_acc) begin
                     s_nxt.ptr = s_r.ptr + (io_word ? DPCAC_INC_WORD : DPCAC_INC_BYTE);
                  end
               end else if (data_acc && s_r.st != DPCAC_LOCKED) begin
                  s_nxt.ready = 1'b0;
               end
            end
         endcase
      end
      // After the host decode, so a peer edge beats a same-cycle clear
      if (peer_req && !s_r.peer_q && s_r.st == DPCAC_ACTIVE) begin
         s_nxt.conflict = 1'b1;
         if (s_r.irq_mode) begin
            s_nxt.irq = 1'b1;
         end
      end
      if (expired && s_r.st == DPCAC_ACTIVE) begin
         s_nxt.st = DPCAC_LOCKED;
         s_nxt.timeout = 1'b1;
         s_nxt.rcons = 1'b0;
         s_nxt.wcons = 1'b0;
         s_nxt.ram_wr = 1'b0;
         s_nxt.ram_rd = 1'b0;
      end
      // Idle RAM port follows the pointer so read data is there at the next strobe;
      // a read therefore needs one free cycle after a write
      if (!s_nxt.ram_wr) begin
         s_nxt.ram_addr = s_nxt.ptr;
      end
      s_nxt.ack_n = !((s_nxt.st == DPCAC_ACTIVE) && !s_nxt.peer_busy);
      // Peer waits while host holds the RAM, unless the peer got there first
      s_nxt.peer_ready = (s_nxt.st != DPCAC_ACTIVE) || s_nxt.peer_busy;
   end

   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         s_r <= '0;
         s_r.timeout_reload_value <= DPCAC_TOR_RESET;
         s_r.ack_n <= 1'b1;
         s_r.peer_ready <= 1'b1;
      end else begin
         s_r <= s_nxt;
      end
   end

   assign io_rdata = s_r.rdata;
   assign io_ready = s_r.ready;
   assign peer_ready = s_r.peer_ready;
   assign ram_addr = s_r.ram_addr;
   assign ram_wr = s_r.ram_wr;
   assign ram_rd = s_r.ram_rd;
   assign ram_word = s_r.ram_word;
   assign ram_wdata = s_r.ram_wdata;
   assign host_irq = s_r.irq;
   assign host_consistency_ack_n = s_r.ack_n;

   a_lock_until_clear: assert property (@(posedge ref_clk) disable iff (!rst_n)
      s_r.st == DPCAC_LOCKED && !(io_wr && io_addr == DPCAC_OFF_REQ) |=> s_r.st == DPCAC_LOCKED)
      else $error("locked state left without clear write");
   a_no_ram_locked: assert property (@(posedge ref_clk) disable iff (!rst_n)
      s_r.st == DPCAC_LOCKED |=> !s_r.ram_wr && !s_r.ram_rd)
      else $error("shared RAM touched while locked");
   a_cancel_read: assert property (@(posedge ref_clk) disable iff (!rst_n)
      io_rd && io_addr == DPCAC_OFF_REQ && s_r.st == DPCAC_ACTIVE && !expired
      |=> s_r.st == DPCAC_IDLE && !s_r.rcons && !s_r.wcons)
      else $error("request read did not cancel");
   a_status_data: assert property (@(posedge ref_clk) disable iff (!rst_n)
      io_rd && io_addr == DPCAC_OFF_REQ |=> s_r.rdata[DPCAC_BIT_TIMEOUT] == $past(s_r.timeout))
      else $error("cancel read lost timeout flag");
   a_status_quiet: assert property (@(posedge ref_clk) disable iff (!rst_n)
      io_rd && io_addr == DPCAC_OFF_STATUS && !expired |=> s_r.st == $past(s_r.st))
      else $error("status read changed state");
   a_conflict_set: assert property (@(posedge ref_clk) disable iff (!rst_n)
      peer_req && !s_r.peer_q && s_r.st == DPCAC_ACTIVE |=> s_r.conflict)
      else $error("conflict flag not set");
   a_ack_low: assert property (@(posedge ref_clk) disable iff (!rst_n)
      !host_consistency_ack_n |-> !peer_ready && s_r.st == DPCAC_ACTIVE)
      else $error("acknowledge without grant");
   a_word_inc: assert property (@(posedge ref_clk) disable iff (!rst_n)
      io_wr && inc_acc && io_word && host_ok |=> s_r.ptr == $past(s_r.ptr) + DPCAC_INC_WORD)
      else $error("word increment wrong");
   a_timeout_lock: assert property (@(posedge ref_clk) disable iff (!rst_n)
      expired && s_r.st == DPCAC_ACTIVE |=> s_r.st == DPCAC_LOCKED ##0 s_r.timeout)
      else $error("expiry did not abort host");
endmodule

// ---- dpcac_peer_model.sv ----
// Purpose: shared RAM and protocol controller stand-in
// Assumes: RAM read data follows the pointer without delay
// Notes: peer keeps the RAM five cycles once let through, then reports done
`timescale 1ns/1ps
module dpcac_peer_model (
   input wire logic ref_clk,
   input wire logic want,
   input wire logic peer_ready,
   input wire logic [13:0] ram_addr,
   input wire logic ram_wr,
   input wire logic ram_word,
   input wire logic [15:0] ram_wdata,
   output logic [15:0] ram_rdata,
   output logic peer_consistency_request,
   output logic peer_done,
   output int got
);
   logic [7:0] mem [0:16383];
   logic [2:0] hold_r;
   logic want_q;
   // Low byte sits at the lower of the two addresses
   assign ram_rdata = {mem[ram_addr + 14'h0001], mem[ram_addr]};
   initial begin
      peer_consistency_request = 1'b0;
      peer_done = 1'b0;
      got = 0;
      hold_r = 3'h0;
      want_q = 1'b0;
   end
   always @(posedge ref_clk) begin
      peer_done <= 1'b0;
      want_q <= want;
      if (ram_wr) begin
         mem[ram_addr] <= ram_wdata[7:0];
         if (ram_word) begin
            mem[ram_addr + 14'h0001] <= ram_wdata[15:8];
         end
      end
      // One access per rising edge of want, so the pin never drops for one cycle only
      if (want && !want_q && !peer_consistency_request) begin
         peer_consistency_request <= 1'b1;
      end else if (peer_consistency_request && peer_ready) begin
         hold_r <= hold_r + 3'h1;
         if (hold_r == 3'h4) begin
            peer_done <= 1'b1;
            peer_consistency_request <= 1'b0;
            got <= got + 1;
            hold_r <= 3'h0;
         end
      end
   end
endmodule

// ---- test_dpram_consistency_access_ctrl.sv ----
// Purpose: self-checking bench for the shared-RAM consistency controller
// Assumes: host strobes last one cycle; braked accesses are retried
// Notes: timer reload kept small so an abort takes a few microseconds
`timescale 1ns/1ps
module test_dpram_consistency_access_ctrl;
   import dpcac_pkg::*;
   logic ref_clk, rst_n, io_wr, io_rd, io_word, io_ready, want, ok_s;
   logic peer_consistency_request, peer_done, peer_ready, ram_wr, ram_rd, ram_word;
   logic host_irq, host_consistency_ack_n;
   logic [7:0] io_addr;
   logic [15:0] io_wdata, io_rdata, ram_wdata, ram_rdata, q_s;
   logic [DPCAC_AW-1:0] ram_addr;
   int got, g0, n0, wr_seen, rd_seen, bad_count, comparisons;
   dpcac_ctrl u_dpcac_ctrl (.ref_clk(ref_clk), .rst_n(rst_n), .io_wr(io_wr), .io_rd(io_rd),
      .io_addr(io_addr), .io_word(io_word), .io_wdata(io_wdata), .io_rdata(io_rdata),
      .io_ready(io_ready), .peer_consistency_request(peer_consistency_request),
      .peer_done(peer_done), .peer_ready(peer_ready), .ram_addr(ram_addr), .ram_wr(ram_wr),
      .ram_rd(ram_rd), .ram_word(ram_word), .ram_wdata(ram_wdata), .ram_rdata(ram_rdata),
      .host_irq(host_irq), .host_consistency_ack_n(host_consistency_ack_n));
   dpcac_peer_model u_dpcac_peer_model (.ref_clk(ref_clk), .want(want),
      .peer_ready(peer_ready), .ram_addr(ram_addr), .ram_wr(ram_wr), .ram_word(ram_word),
      .ram_wdata(ram_wdata), .ram_rdata(ram_rdata), .got(got),
      .peer_consistency_request(peer_consistency_request), .peer_done(peer_done));
   initial begin
      ref_clk = 1'b0;
      forever #2.5 ref_clk = ~ref_clk;
   end
   always @(posedge ref_clk) begin
      if (ram_wr === 1'b1) wr_seen++;
      if (ram_rd === 1'b1) rd_seen++;
   end
   task automatic close_out;
      $display("comparisons %0d mismatches %0d", comparisons, bad_count);
      if (bad_count == 0 && comparisons > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask
   task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
      comparisons++;
      if (g !== e) begin
         bad_count++;
         $display("unexpected %s: expected %h seen %h", n, e, g);
      end
   endtask
   task automatic chkb(input string n, input logic e, input logic g);
      chk(n, {15'h0000, e}, {15'h0000, g});
   endtask
   // A braked access shows no ready; the strobe is then simply tried again
   task automatic io(input logic w_en, input logic [7:0] a, input logic w,
         input logic [15:0] d, input int tries);
      ok_s = 1'b0;
      repeat (tries) if (!ok_s) begin
         @(posedge ref_clk);
         #1 {io_wr, io_rd, io_addr, io_word, io_wdata} = {w_en, !w_en, a, w, d};
         @(posedge ref_clk);
         #1 {io_wr, io_rd} = 2'b00;
         if (io_ready !== 1'b1) @(posedge ref_clk);
         #1 ok_s = (io_ready === 1'b1);
         q_s = io_rdata;
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic w, input logic [15:0] d);
      io(1'b1, a, w, d, 20);
      chkb("write ready", 1'b1, ok_s);
   endtask
   task automatic rd(input logic [7:0] a, input logic w);
      io(1'b0, a, w, 16'h0000, 20);
      chkb("read ready", 1'b1, ok_s);
   endtask
   task automatic grant(input logic [7:0] req);
      wr(DPCAC_OFF_REQ, 1'b0, {8'h00, req});
      q_s = 16'hffff;
      for (int i = 0; i < 20 && q_s[DPCAC_BIT_ACK] !== 1'b0; i++) rd(DPCAC_OFF_STATUS, 1'b0);
      chkb("ack bit", 1'b0, q_s[DPCAC_BIT_ACK]);
      chkb("ack pin", 1'b0, host_consistency_ack_n);
   endtask
   task automatic served(input int lim);
      for (int i = 0; i < lim && got == g0; i++) @(posedge ref_clk);
      #1 want = 1'b0;
      chk("peer served", 16'(g0 + 1), 16'(got));
   endtask
   task automatic t_reset;
      chkb("ack idle", 1'b1, host_consistency_ack_n);
      rd(DPCAC_OFF_STATUS, 1'b0);
      n0 = q_s;
      rd(DPCAC_OFF_STATUS, 1'b0);
      chk("status twice", 16'(n0), q_s);
      io(1'b1, DPCAC_OFF_DATA, 1'b1, 16'h0000, 1);
      chkb("ungranted access", 1'b0, ok_s);
      $display("test reset done");
   endtask
   task automatic t_write;
      grant(DPCAC_REQ_WRITE);
      wr(DPCAC_OFF_PTR, 1'b1, 16'h0010);
      wr(DPCAC_OFF_DATA_INC, 1'b1, 16'ha55a);
      wr(DPCAC_OFF_DATA_INC, 1'b0, 16'h003c);
      wr(DPCAC_OFF_DATA, 1'b1, 16'h1234);
      wr(DPCAC_OFF_PTR, 1'b1, 16'h0010);
      n0 = rd_seen;
      rd(DPCAC_OFF_DATA_INC, 1'b1);
      chk("word read", 16'ha55a, q_s);
      rd(DPCAC_OFF_DATA_INC, 1'b0);
      chk("byte read", 16'h003c, {8'h00, q_s[7:0]});
      rd(DPCAC_OFF_DATA, 1'b0);
      chk("byte no inc", 16'h0034, {8'h00, q_s[7:0]});
      rd(DPCAC_OFF_DATA, 1'b0);
      chk("byte again", 16'h0034, {8'h00, q_s[7:0]});
      @(posedge ref_clk);
      #1 chk("ram reads", 16'(n0 + 4), 16'(rd_seen));
      rd(DPCAC_OFF_REQ, 1'b0);
      chkb("clean end", 1'b0, q_s[DPCAC_BIT_CONFLICT] | q_s[DPCAC_BIT_TIMEOUT]);
      chkb("released", 1'b1, host_consistency_ack_n);
      $display("test write done");
   endtask
   task automatic t_conflict;
      grant(DPCAC_REQ_READ);
      g0 = got;
      want = 1'b1;
      repeat (20) @(posedge ref_clk);
      #1 chkb("peer braked", 1'b0, peer_ready);
      rd(DPCAC_OFF_REQ, 1'b0);
      chkb("conflict", 1'b1, q_s[DPCAC_BIT_CONFLICT]);
      chkb("no timeout", 1'b0, q_s[DPCAC_BIT_TIMEOUT]);
      served(60);
      wr(DPCAC_OFF_REQ, 1'b0, {8'h00, DPCAC_REQ_CLEAR});
      rd(DPCAC_OFF_STATUS, 1'b0);
      chkb("conflict cleared", 1'b0, q_s[DPCAC_BIT_CONFLICT]);
      $display("test conflict done");
   endtask
   task automatic t_timeout;
      wr(DPCAC_OFF_TOR, 1'b1, 16'h0002);
      grant(DPCAC_REQ_WRITE);
      g0 = got;
      want = 1'b1;
      served(1200);
      chkb("host aborted", 1'b1, host_consistency_ack_n);
      n0 = wr_seen;
      wr(DPCAC_OFF_DATA, 1'b1, 16'hbeef);
      @(posedge ref_clk);
      #1 chk("locked write", 16'(n0), 16'(wr_seen));
      rd(DPCAC_OFF_REQ, 1'b0);
      chkb("timeout flag", 1'b1, q_s[DPCAC_BIT_TIMEOUT]);
      wr(DPCAC_OFF_REQ, 1'b0, {8'h00, DPCAC_REQ_CLEAR});
      rd(DPCAC_OFF_STATUS, 1'b0);
      chkb("timeout cleared", 1'b0, q_s[DPCAC_BIT_TIMEOUT] | q_s[DPCAC_BIT_LOCK]);
      // Grant, write and cancel read repeated after the failed one
      grant(DPCAC_REQ_WRITE);
      n0 = wr_seen;
      wr(DPCAC_OFF_DATA, 1'b1, 16'hbeef);
      @(posedge ref_clk);
      #1 chk("repeat write", 16'(n0 + 1), 16'(wr_seen));
      rd(DPCAC_OFF_REQ, 1'b0);
      chkb("repeat clean", 1'b0, q_s[DPCAC_BIT_TIMEOUT]);
      $display("test timeout done");
   endtask
   task automatic t_irq;
      wr(DPCAC_OFF_MODE, 1'b1, 16'h0001);
      grant(DPCAC_REQ_READ);
      g0 = got;
      want = 1'b1;
      for (int i = 0; i < 20 && host_irq !== 1'b1; i++) @(posedge ref_clk);
      #1 chkb("irq raised", 1'b1, host_irq);
      repeat (1200) @(posedge ref_clk);
      #1 chkb("no abort", 1'b0, host_consistency_ack_n);
      rd(DPCAC_OFF_REQ, 1'b0);
      served(60);
      chkb("irq cleared", 1'b0, host_irq);
      $display("test interrupt done");
   endtask
   initial begin
      {rst_n, io_wr, io_rd, io_word, want} = 5'h00;
      io_addr = 8'h00;
      io_wdata = 16'h0000;
      repeat (4) @(posedge ref_clk);
      #1 rst_n = 1'b1;
      t_reset();
      t_write();
      t_conflict();
      t_timeout();
      t_irq();
      close_out();
   end
   initial begin
      repeat (20000) @(posedge ref_clk);
      bad_count++;
      close_out();
   end
endmodule
